/* File: logic/pcs_clock_ctrl.v */
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "pcs_consts.vh"

module pcs_clock_ctrl #(
  parameter OST_CYCLES = `PCS_OST_CYCLES
) (
  input wire REF_CLK,
  input wire RST_B,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire [2:0] PWR_STATE,
  input wire CPU_ON_INT_OSC,
  input wire PLL_LOCK,
  input wire SUB_CLK,
  output reg MAIN_OSC_EN,
  output reg MAIN_SYS_CLK_EN,
  output reg INT_SYS_CLK_EN,
  output reg CPU_CLK_EN,
  output reg PERIPH_CLK_EN,
  output reg WDT_INT_OSC_CLK_EN,
  output reg SUB_OSC_EN,
  output reg WT_SUB_CLK_EN,
  output reg PLL_OSC_EN,
  output reg PLL_MAIN_CLK_EN,
  output reg MULT_CLK_SELECT,
  output reg [2:0] CLK_RATIO,
  output reg [3:0] DIVIDER_SELECT,
  output reg SYS_CLK_OUT_O,
  output reg SYS_CLK_OUT_OE
);

  function st_is;
    input [2:0] st;
    input [2:0] code;
    begin
      st_is = (st == code);
    end
  endfunction

  // Write strobe for one register offset
  function wr_at;
    input pend;
    input [7:0] addr;
    input [7:0] off;
    begin
      wr_at = pend & (addr == off);
    end
  endfunction

  // Two-stage synchronisers for outside levels
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  reg sub_prev_q;
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sub_prev_q <= 1'b0;
    end else begin
      sync1_q <= {SUB_CLK, PLL_LOCK, CPU_ON_INT_OSC, PWR_STATE};
      sync2_q <= sync1_q;
      sub_prev_q <= sync2_q[5];
    end
  end
  wire [2:0] st = sync2_q[2:0];
  wire int_osc_s = sync2_q[3];
  wire lock_s = sync2_q[4];
  wire sub_edge = sync2_q[5] & ~sub_prev_q;

  // Registers
  reg [7:0] ccs_q;
  reg pll_run_q;
  reg pll_run_d;
  reg mult_sel_q;
  reg mult_sel_d;
  reg [3:0] div_sel_q;
  reg [3:0] div_sel_d;
  reg main_halt_q;
  reg main_halt_d;
  reg clk_src_q;
  reg clk_src_d;
  reg system_clock_out_pin_mode_q;
  reg system_clock_out_pin_mode_d;
  reg lock_q;

  // Reset images of the writable registers
  localparam [7:0] PLLC_RST = `PCS_RST_PLLC;
  localparam [7:0] PROC_RST = `PCS_RST_PROC;
  localparam [7:0] PORT_RST = `PCS_RST_PORT;

  // AHB-Lite address phase capture
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg wr_lane0_q;
  wire take = HSEL & HTRANS[1] & HREADY;
  wire lane0 = (HSIZE == 3'h2) | (HADDR[1:0] == 2'h0);
  wire in_block = (HADDR[31:8] == 24'h000000);
  wire size_ok = (HSIZE <= 3'h2);

  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_lane0_q <= 1'b0;
    end else begin
      wr_pend_q <= take & HWRITE & in_block & size_ok;
      wr_addr_q <= {HADDR[7:2], 2'h0};
      wr_lane0_q <= lane0;
    end
  end

  wire wr_ok = wr_pend_q & wr_lane0_q;
  wire [7:0] wb = HWDATA[7:0];

  // Lock gating of the mode-select bit
  wire pll_locked = lock_s & pll_run_q;

  always @* begin
    pll_run_d = pll_run_q;
    mult_sel_d = mult_sel_q;
    div_sel_d = div_sel_q;
    main_halt_d = main_halt_q;
    system_clock_out_pin_mode_d = system_clock_out_pin_mode_q;
    clk_src_d = clk_src_q;
    if (wr_at(wr_ok, wr_addr_q, `PCS_OFF_PLLC)) begin
      pll_run_d = wb[`PCS_BIT_PLL_RUN];
      mult_sel_d = wb[`PCS_BIT_MULT_SEL] & pll_locked;
    end
    if (wr_at(wr_ok, wr_addr_q, `PCS_OFF_PROC)) begin
      div_sel_d = wb[3:0];
      main_halt_d = wb[`PCS_BIT_MAIN_HALT];
    end
    if (wr_at(wr_ok, wr_addr_q, `PCS_OFF_PORT)) begin
      system_clock_out_pin_mode_d = wb[`PCS_BIT_SYSTEM_CLOCK_OUT_PIN_MODE];
    end
    // Source flag follows the select on a subclock edge
    if (sub_edge) begin
      clk_src_d = div_sel_q[`PCS_BIT_SUB_SEL];
    end
  end

  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ccs_q <= `PCS_RST_CCS;
      pll_run_q <= PLLC_RST[`PCS_BIT_PLL_RUN];
      mult_sel_q <= PLLC_RST[`PCS_BIT_MULT_SEL];
      div_sel_q <= PROC_RST[3:0];
      main_halt_q <= PROC_RST[`PCS_BIT_MAIN_HALT];
      clk_src_q <= PROC_RST[`PCS_BIT_CLK_SRC];
      system_clock_out_pin_mode_q <= PORT_RST[`PCS_BIT_SYSTEM_CLOCK_OUT_PIN_MODE];
      lock_q <= 1'b0;
    end else begin
      ccs_q <= {7'h00, int_osc_s};
      pll_run_q <= pll_run_d;
      mult_sel_q <= mult_sel_d;
      div_sel_q <= div_sel_d;
      main_halt_q <= main_halt_d;
      clk_src_q <= clk_src_d;
      system_clock_out_pin_mode_q <= system_clock_out_pin_mode_d;
      lock_q <= pll_locked;
    end
  end

  // Writable registers read from next values so a read right after a write sees it; status and lock read from their registers
  reg [7:0] rd_d;
  always @* begin
    case (HADDR[7:0])
      `PCS_OFF_CCS: rd_d = ccs_q;
      `PCS_OFF_PLLC: rd_d = {6'h00, mult_sel_d, pll_run_d};
      `PCS_OFF_PROC: rd_d = {1'b0, main_halt_d, 1'b0, clk_src_d, div_sel_d};
      `PCS_OFF_LOCK: rd_d = {7'h00, lock_q};
      `PCS_OFF_PORT: rd_d = {6'h00, system_clock_out_pin_mode_d, 1'b0};
      default: rd_d = 8'h00;
    endcase
    if (!in_block) begin
      rd_d = 8'h00;
    end
  end

  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      // Read data moves only on a taken read, so it stands through idle cycles
      if (take && !HWRITE) begin
        HRDATA <= {24'h000000, rd_d};
      end
    end
  end

  // Stabilization counter: PLL may start after half of it
  reg [31:0] ost_cnt_q;
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ost_cnt_q <= 32'h00000000;
    end else if (!st_is(st, `PCS_ST_OST)) begin
      ost_cnt_q <= 32'h00000000;
    end else if (ost_cnt_q < OST_CYCLES) begin
      ost_cnt_q <= ost_cnt_q + 32'h00000001;
    end
  end
  wire ost_half = (ost_cnt_q >= (OST_CYCLES >> 1));

  // Clock gating per power state; subclock columns follow the source flag
  wire on_sub = clk_src_q;
  wire main_ok = ~main_halt_q;
  reg main_osc;
  reg main_sys;
  reg int_sys;
  reg periph;
  reg cpu_clk;
  reg pll_osc_ok;
  reg pll_clk;
  always @* begin
    main_osc = main_ok;
    main_sys = 1'b0;
    int_sys = 1'b0;
    periph = 1'b0;
    cpu_clk = 1'b0;
    pll_osc_ok = main_ok & pll_run_q;
    pll_clk = 1'b0;
    case (st)
      `PCS_ST_RUN: begin
        main_sys = ~on_sub | main_ok;
        int_sys = 1'b1;
        periph = ~on_sub | main_ok;
        cpu_clk = 1'b1;
        pll_clk = pll_osc_ok & pll_locked;
      end
      `PCS_ST_OST: begin
        // PLL may only start once half the count has run
        pll_osc_ok = main_ok & pll_run_q & ost_half;
        pll_clk = pll_osc_ok & pll_locked;
      end
      `PCS_ST_HALT: begin
        main_sys = 1'b1;
        int_sys = 1'b1;
        periph = 1'b1;
        pll_clk = pll_osc_ok & pll_locked;
      end
      `PCS_ST_DOZE1: begin
        pll_clk = pll_osc_ok & pll_locked;
      end
      `PCS_ST_DOZE2: begin
        pll_osc_ok = 1'b0;
      end
      `PCS_ST_STOP: begin
        main_osc = 1'b0;
        pll_osc_ok = 1'b0;
      end
      `PCS_ST_SUB_IDLE: begin
        pll_clk = pll_osc_ok & pll_locked;
      end
      default: begin
        pll_clk = 1'b0;
      end
    endcase
  end

  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MAIN_OSC_EN <= 1'b0;
      MAIN_SYS_CLK_EN <= 1'b0;
      INT_SYS_CLK_EN <= 1'b0;
      CPU_CLK_EN <= 1'b0;
      PERIPH_CLK_EN <= 1'b0;
      WDT_INT_OSC_CLK_EN <= 1'b0;
      SUB_OSC_EN <= 1'b1;
      WT_SUB_CLK_EN <= 1'b1;
      PLL_OSC_EN <= 1'b0;
      PLL_MAIN_CLK_EN <= 1'b0;
      MULT_CLK_SELECT <= 1'b0;
      CLK_RATIO <= `PCS_THRU_MULT;
      DIVIDER_SELECT <= 4'h0;
    end else begin
      MAIN_OSC_EN <= main_osc;
      MAIN_SYS_CLK_EN <= main_sys;
      INT_SYS_CLK_EN <= int_sys;
      CPU_CLK_EN <= cpu_clk;
      PERIPH_CLK_EN <= periph;
      WDT_INT_OSC_CLK_EN <= 1'b1;
      SUB_OSC_EN <= 1'b1;
      WT_SUB_CLK_EN <= 1'b1;
      PLL_OSC_EN <= pll_osc_ok;
      PLL_MAIN_CLK_EN <= pll_clk;
      MULT_CLK_SELECT <= mult_sel_q;
      CLK_RATIO <= mult_sel_q ? `PCS_PLL_MULT : `PCS_THRU_MULT;
      DIVIDER_SELECT <= div_sel_q;
    end
  end

  // Clock output: main clock divided by 2^(sel+1), or subclock edges
  reg [7:0] div_cnt_q;
  wire [7:0] div_top = (8'h01 << div_sel_q[2:0]) - 8'h01;
  wire div_hit = (div_cnt_q >= div_top);
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt_q <= 8'h00;
      SYS_CLK_OUT_O <= 1'b0;
      SYS_CLK_OUT_OE <= 1'b0;
    end else begin
      SYS_CLK_OUT_OE <= system_clock_out_pin_mode_q;
      div_cnt_q <= div_hit ? 8'h00 : div_cnt_q + 8'h01;
      if (!int_sys || !system_clock_out_pin_mode_q) begin
        SYS_CLK_OUT_O <= 1'b0;
      end else if (div_sel_q[`PCS_BIT_SUB_SEL] ? sub_edge : div_hit) begin
        SYS_CLK_OUT_O <= ~SYS_CLK_OUT_O;
      end
    end
  end

endmodule // pcs_clock_ctrl

/* File: logic/pcs_consts.vh */
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// Register byte offsets
`define PCS_OFF_CCS 8'h00
`define PCS_OFF_PLLC 8'h04
`define PCS_OFF_PROC 8'h08
`define PCS_OFF_LOCK 8'h0C
`define PCS_OFF_PORT 8'h10

// Reset values
`define PCS_RST_CCS 8'h00
`define PCS_RST_PLLC 8'h01
`define PCS_RST_PROC 8'h00
`define PCS_RST_PORT 8'h00

// Field positions
`define PCS_BIT_INT_OSC 0
`define PCS_BIT_PLL_RUN 0
`define PCS_BIT_MULT_SEL 1
`define PCS_BIT_SUB_SEL 3
`define PCS_BIT_CLK_SRC 4
`define PCS_BIT_MAIN_HALT 6
`define PCS_BIT_LOCK 0
`define PCS_BIT_SYSTEM_CLOCK_OUT_PIN_MODE 1

// Power state codes on PWR_STATE
`define PCS_ST_RUN 3'h0
`define PCS_ST_OST 3'h1
`define PCS_ST_HALT 3'h2
`define PCS_ST_DOZE1 3'h3
`define PCS_ST_DOZE2 3'h4
`define PCS_ST_STOP 3'h5
`define PCS_ST_SUB_IDLE 3'h6

// PLL ratio and timing
`define PCS_PLL_MULT 3'h4
`define PCS_THRU_MULT 3'h1
`define PCS_CLK_HZ 10000000
`define PCS_OST_US 1000
`define PCS_OST_CYCLES ((`PCS_OST_US * (`PCS_CLK_HZ / 1000000)))

`endif

/* File: testbench/pcs_clock_ctrl_monitor.sv */
`timescale 1ns/1ps
`include "pcs_consts.vh"
module pcs_monitor (
  input wire REF_CLK,
  input wire RST_B,
  input wire [2:0] PWR_STATE,
  input wire PLL_LOCK,
  input wire MAIN_OSC_EN,
  input wire MAIN_SYS_CLK_EN,
  input wire INT_SYS_CLK_EN,
  input wire PERIPH_CLK_EN,
  input wire SUB_OSC_EN,
  input wire WT_SUB_CLK_EN,
  input wire PLL_MAIN_CLK_EN,
  input wire MULT_CLK_SELECT,
  input wire [2:0] CLK_RATIO,
  input wire SYS_CLK_OUT_O
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  a_sub_always: assert property (SUB_OSC_EN && WT_SUB_CLK_EN)
    else $error("subclock stopped");
  a_stop_quiet: assert property ((PWR_STATE == `PCS_ST_STOP)[*4] |-> !MAIN_OSC_EN)
    else $error("main osc runs in stop");
  a_halt_main: assert property ((PWR_STATE == `PCS_ST_HALT)[*4] |-> MAIN_SYS_CLK_EN)
    else $error("main clock off in halt");
  a_halt_int: assert property ((PWR_STATE == `PCS_ST_HALT)[*4] |-> INT_SYS_CLK_EN)
    else $error("system clock off in halt");
  a_doze_periph: assert property ((PWR_STATE == `PCS_ST_DOZE1)[*4] |-> !PERIPH_CLK_EN)
    else $error("peripheral clock in doze");
  a_doze2_pll: assert property ((PWR_STATE == `PCS_ST_DOZE2)[*4] |-> !PLL_MAIN_CLK_EN)
    else $error("pll clock in deep doze");
  a_pin_low: assert property (!INT_SYS_CLK_EN[*3] |-> !SYS_CLK_OUT_O)
    else $error("clock pin not low");
  a_ratio_mode: assert property ($stable(MULT_CLK_SELECT) |->
    CLK_RATIO == (MULT_CLK_SELECT ? 3'h4 : 3'h1))
    else $error("wrong ratio");
  a_select_lock: assert property ($rose(MULT_CLK_SELECT) |-> $past(PLL_LOCK, 4))
    else $error("select without lock");
  c_halt: cover property (PWR_STATE == `PCS_ST_HALT && INT_SYS_CLK_EN);
  c_mult: cover property ($rose(MULT_CLK_SELECT));
  c_pin: cover property ($rose(SYS_CLK_OUT_O));
endmodule // pcs_monitor
bind pcs_clock_ctrl pcs_monitor u_mon (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .PWR_STATE(PWR_STATE), .PLL_LOCK(PLL_LOCK), .MAIN_OSC_EN(MAIN_OSC_EN),
  .MAIN_SYS_CLK_EN(MAIN_SYS_CLK_EN), .INT_SYS_CLK_EN(INT_SYS_CLK_EN),
  .PERIPH_CLK_EN(PERIPH_CLK_EN), .SUB_OSC_EN(SUB_OSC_EN), .WT_SUB_CLK_EN(WT_SUB_CLK_EN),
  .PLL_MAIN_CLK_EN(PLL_MAIN_CLK_EN), .MULT_CLK_SELECT(MULT_CLK_SELECT),
  .CLK_RATIO(CLK_RATIO), .SYS_CLK_OUT_O(SYS_CLK_OUT_O));

/* File: testbench/pcs_far_side.sv */
`timescale 1ns/1ps
module pcs_far_side #(
  parameter int LOCK_CYC = 20
) (
  input wire clk,
  input wire rst_b,
  input wire pll_osc_en,
  input wire lock_ok,
  output logic pll_lock,
  output logic sub_clk
);
  int cnt;
  initial sub_clk = 1'b0;
  // Subclock oscillator runs free in every state, reset included
  always #400 sub_clk = ~sub_clk;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
    end else if (!pll_osc_en) begin
      cnt <= 0;
    end else if (cnt < LOCK_CYC) begin
      cnt <= cnt + 1;
    end
  end
  // Lock only after the oscillator has run its settling time
  assign pll_lock = lock_ok && (cnt == LOCK_CYC);
endmodule // pcs_far_side

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "pcs_consts.vh"
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] pwr = `PCS_ST_RUN;
  logic int_osc = 1'b0;
  logic lock_ok = 1'b0;
  logic [31:0] rd;
  logic prev;
  wire [31:0] hrdata;
  wire hready, pll_lock, sub_clk, osc_en, int_en, wdt_en, pll_en, mult, oe, pin;
  wire cpu, hresp;
  wire [3:0] dsel;
  wire [2:0] ratio;
  int n;
  int miscompares = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  pcs_clock_ctrl #(.OST_CYCLES(16)) dut (.REF_CLK(clk), .RST_B(rst_b), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .PWR_STATE(pwr),
    .CPU_ON_INT_OSC(int_osc), .PLL_LOCK(pll_lock), .SUB_CLK(sub_clk), .MAIN_OSC_EN(osc_en),
    .MAIN_SYS_CLK_EN(), .INT_SYS_CLK_EN(int_en), .CPU_CLK_EN(cpu), .PERIPH_CLK_EN(),
    .WDT_INT_OSC_CLK_EN(wdt_en), .SUB_OSC_EN(), .WT_SUB_CLK_EN(), .PLL_OSC_EN(pll_en),
    .PLL_MAIN_CLK_EN(), .MULT_CLK_SELECT(mult), .CLK_RATIO(ratio), .DIVIDER_SELECT(dsel),
    .SYS_CLK_OUT_O(pin), .SYS_CLK_OUT_OE(oe));
  pcs_far_side far (.clk(clk), .rst_b(rst_b), .pll_osc_en(pll_en), .lock_ok(lock_ok),
    .pll_lock(pll_lock), .sub_clk(sub_clk));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("oe", 0, oe);
    bus(0, `PCS_OFF_CCS, 0);
    chk("status", 0, rd);
    bus(0, `PCS_OFF_PLLC, 0);
    chk("pll_control", 32'h1, rd);
    bus(0, 32'h20, 0);
    chk("unmapped", 0, rd);
    int_osc <= 1'b1;
    repeat (4) @(posedge clk);
    bus(0, `PCS_OFF_CCS, 0);
    chk("status", 32'h1, rd);
    bus(1, `PCS_OFF_PLLC, 32'hFF);
    bus(0, `PCS_OFF_PLLC, 0);
    chk("unlocked select", 32'h1, rd);
    lock_ok <= 1'b1;
    repeat (30) @(posedge clk);
    bus(0, `PCS_OFF_LOCK, 0);
    chk("lock", 32'h1, rd);
    bus(1, `PCS_OFF_PLLC, 32'h3);
    bus(0, `PCS_OFF_PLLC, 0);
    chk("locked select", 32'h3, rd);
    repeat (2) @(posedge clk);
    chk("ratio", 32'h4, ratio);
    bus(1, `PCS_OFF_PLLC, 0);
    repeat (4) @(posedge clk);
    chk("pll off", 0, pll_en);
    bus(1, `PCS_OFF_PLLC, 32'h1);
    for (int s = 1; s < 6; s++) begin
      pwr <= s[2:0];
      repeat (6) @(posedge clk);
      chk("int_sys", (8'h04 >> s) & 8'h01, int_en);
      chk("main_osc", (8'h1E >> s) & 8'h01, osc_en);
      chk("wdt", 1, wdt_en);
      chk("cpu", 0, cpu);
      chk("pll_osc", (8'h0C >> s) & 8'h01, pll_en);
    end
    pwr <= `PCS_ST_HALT;
    bus(1, `PCS_OFF_PORT, 32'h2);
    repeat (4) @(posedge clk);
    chk("oe", 1, oe);
    n = 0;
    prev = pin;
    repeat (16) begin
      @(posedge clk);
      n += (pin !== prev);
      prev = pin;
    end
    chk("toggling", 16, n);
    pwr <= `PCS_ST_STOP;
    repeat (6) @(posedge clk);
    chk("pin", 0, pin);
    pwr <= `PCS_ST_RUN;
    bus(1, `PCS_OFF_PROC, 32'h8);
    repeat (12) @(posedge clk);
    bus(0, `PCS_OFF_PROC, 0);
    chk("source flag", 32'h18, rd);
    chk("divider", 32'h8, dsel);
    chk("resp", 0, hresp);
    bus(1, `PCS_OFF_PROC, 32'h48);
    repeat (4) @(posedge clk);
    chk("main_osc", 0, osc_en);
    chk("int_sys", 1, int_en);
    stop_test;
  end
endmodule // testbench
